// ==== mer_core.sv ====
module mer_core
    import mer_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic req_valid, // Request present
    output logic req_ready, // Request taken when high with valid
    input wire mer_req_t req, // Request fields
    input wire logic [63:0] in_words, // Four input words, word 0 low
    output logic rsp_valid, // Answer present, one cycle
    output mer_rsp_t rsp_ff, // Answer fields
    output logic [143:0] cfg_ff, // Output words, word 0 low
    output logic [31:0] cpt_ff, // Counts per turn, joined
    output logic preset_ff, // Preset command pulse
    output logic store_ff // Store command pulse
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Word address lies in the output area
    function automatic logic is_out(input logic [15:0] a);
        is_out = (a >= OUT_BASE) && (a <= OUT_LAST);
    endfunction

    // Word address lies in the input area
    function automatic logic is_in(input logic [15:0] a);
        is_in = (a <= IN_LAST);
    endfunction

    // Coil address lies in the output bit area
    function automatic logic is_coil(input logic [15:0] a);
        is_coil = (a >= COIL_BASE) && (a <= COIL_LAST);
    endfunction

    // Legal value check for one output word
    function automatic logic val_ok(input logic [3:0] idx,
                                    input logic [15:0] v,
                                    input logic [143:0] cur);
        logic [31:0] cpt;
        cpt = 32'h0000_0000;
        val_ok = 1'b1;
        if (idx == IDX_CMD) begin
            val_ok = (v & CMD_RSVD) == 16'h0000;
        end else if (idx == IDX_VEL) begin
            val_ok = (v == VEL_PPS) || (v == VEL_PPMS) ||
                     (v == VEL_PPM) || (v == VEL_RPM);
        end else if (idx == IDX_CPT_LO || idx == IDX_CPT_HI) begin
            // Pair is checked as one 32-bit value, low word first
            if (idx == IDX_CPT_LO) begin
                cpt = {cur[IDX_CPT_HI*16 +: 16], v};
            end else begin
                cpt = {v, cur[IDX_CPT_LO*16 +: 16]};
            end
            val_ok = (cpt >= CPT_MIN) && (cpt <= CPT_MAX);
        end
    endfunction

    // ------------------------------------------------------------
    // Request capture and sequencing
    // ------------------------------------------------------------
    mer_state_t state_ff; // Sequencer state
    mer_req_t req_ff; // Captured request
    logic [7:0] exc_ff; // Decided exception
    logic [3:0] widx_ff; // Target output word index
    logic [3:0] bit_ff; // Target bit within word
    logic rd_in_ff; // Read comes from the input area
    logic [1:0] in_idx_ff; // Input word index
    logic [15:0] mem_rdata; // Output word read data
    logic [15:0] new_word; // Word value to be written
    logic mem_we; // Output word write strobe
    logic [15:0] caddr; // Coil offset from base
    logic is_write; // Request modifies an output word

    assign req_ready = (state_ff == ST_IDLE);
    assign caddr = req.addr - COIL_BASE;

    // Sequencer: idle, fetch word, check, write, answer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: if (req_valid) state_ff <= ST_READ;
                ST_READ: state_ff <= ST_CHECK;
                ST_CHECK: state_ff <= ST_WRITE;
                ST_WRITE: state_ff <= ST_DONE;
                ST_DONE: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Function and address decode on acceptance
    always_ff @(posedge clk) begin
        if (rst) begin
            req_ff <= '0;
            exc_ff <= EXC_NONE;
            widx_ff <= 4'h0;
            bit_ff <= 4'h0;
            rd_in_ff <= 1'b0;
            in_idx_ff <= 2'h0;
        end else if (req_valid && req_ready) begin
            req_ff <= req;
            rd_in_ff <= 1'b0;
            in_idx_ff <= req.addr[1:0];
            widx_ff <= 4'(req.addr - OUT_BASE);
            bit_ff <= 4'h0;
            exc_ff <= EXC_ADDR;
            unique case (req.func)
                FC_RD_COILS, FC_WR_COIL, FC_WR_COILS: begin
                    // Bit n of word k sits at base + 16k + n
                    widx_ff <= caddr[7:4];
                    bit_ff <= caddr[3:0];
                    if (is_coil(req.addr)) exc_ff <= EXC_NONE;
                end
                FC_RD_DIN: begin
                    rd_in_ff <= 1'b1;
                    in_idx_ff <= req.addr[5:4];
                    bit_ff <= req.addr[3:0];
                    if (req.addr <= DIN_LAST) begin
                        exc_ff <= EXC_NONE;
                    end
                end
                FC_RD_INREG: begin
                    rd_in_ff <= 1'b1;
                    if (is_in(req.addr)) exc_ff <= EXC_NONE;
                end
                FC_RD_HOLD, FC_RD_WR: begin
                    // Reads reach both areas
                    rd_in_ff <= is_in(req.addr);
                    if (is_in(req.addr) || is_out(req.addr)) begin
                        exc_ff <= EXC_NONE;
                    end
                end
                FC_WR_REG, FC_WR_REGS, FC_MASK_WR: begin
                    // Input area never writable
                    if (is_out(req.addr)) begin
                        exc_ff <= EXC_NONE;
                    end
                end
                default: exc_ff <= EXC_FUNC;
            endcase
        end else if (state_ff == ST_CHECK && exc_ff == EXC_NONE &&
                     is_write && !val_ok(widx_ff, new_word, cfg_ff)) begin
            exc_ff <= EXC_VALUE;
        end
    end

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    assign is_write = (req_ff.func == FC_WR_COIL) ||
                      (req_ff.func == FC_WR_COILS) ||
                      (req_ff.func == FC_WR_REG) ||
                      (req_ff.func == FC_WR_REGS) ||
                      (req_ff.func == FC_MASK_WR);

    // New word value from write kind
    always_comb begin
        new_word = mem_rdata;
        unique case (req_ff.func)
            FC_WR_COIL, FC_WR_COILS: new_word[bit_ff] = req_ff.wdata[0];
            FC_MASK_WR: new_word = (mem_rdata & req_ff.wdata) |
                                   (req_ff.omask & ~req_ff.wdata);
            default: new_word = req_ff.wdata;
        endcase
    end

    // Accepted data applied at once; rejected data leaves words alone
    assign mem_we = (state_ff == ST_WRITE) && is_write &&
                    (exc_ff == EXC_NONE);

    mer_word_mem #(
        .DEPTH(OUT_WORDS)
    ) u_mem (
        .clk(clk),
        .rst(rst),
        .raddr(widx_ff),
        .rdata_ff(mem_rdata),
        .we(mem_we),
        .waddr(widx_ff),
        .wdata(new_word)
    );

    // Shadow of output words for the user side
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff <= {RST_TMR_HI, RST_TMR_LO, RST_VEL, RST_CPT_HI,
                       RST_CPT_LO, RST_CFG, RST_PRE_HI, RST_PRE_LO,
                       RST_CMD};
        end else if (mem_we) begin
            cfg_ff[widx_ff*16 +: 16] <= new_word;
        end
    end

    // Counts per turn joined from its low and high words
    always_ff @(posedge clk) begin
        if (rst) begin
            cpt_ff <= {RST_CPT_HI, RST_CPT_LO};
        end else begin
            cpt_ff <= {cfg_ff[IDX_CPT_HI*16 +: 16],
                       cfg_ff[IDX_CPT_LO*16 +: 16]};
        end
    end

    // Command nibbles fire on a 0x2 to 0xD transition
    always_ff @(posedge clk) begin
        if (rst) begin
            preset_ff <= 1'b0;
            store_ff <= 1'b0;
        end else begin
            preset_ff <= mem_we && widx_ff == IDX_CMD &&
                         mem_rdata[3:0] == CMD_ARM &&
                         new_word[3:0] == CMD_FIRE;
            store_ff <= mem_we && widx_ff == IDX_CMD &&
                        mem_rdata[7:4] == CMD_ARM &&
                        new_word[7:4] == CMD_FIRE;
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    logic [15:0] in_word; // Selected input word

    assign in_word = in_words[in_idx_ff*16 +: 16];

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_ff <= '0;
        end else if (state_ff == ST_WRITE) begin
            rsp_ff.exc <= exc_ff;
            if (exc_ff != EXC_NONE) begin
                rsp_ff.rdata <= 16'h0000;
            end else if (req_ff.func == FC_RD_DIN) begin
                rsp_ff.rdata <= {15'h0000, in_word[bit_ff]};
            end else if (req_ff.func == FC_RD_COILS) begin
                rsp_ff.rdata <= {15'h0000, mem_rdata[bit_ff]};
            end else if (rd_in_ff) begin
                rsp_ff.rdata <= in_word;
            end else begin
                rsp_ff.rdata <= is_write ? new_word : mem_rdata;
            end
        end
    end

    assign rsp_valid = (state_ff == ST_DONE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_take;
        req_valid && req_ready;
    endsequence

    a_answer_time: assert property (@(posedge clk) disable iff (rst)
        s_take |-> ##4 rsp_valid)
        else $error("answer not four cycles after request");

    a_bad_func: assert property (@(posedge clk) disable iff (rst)
        s_take and (req.func == 8'h07)
        |-> ##4 rsp_ff.exc == EXC_FUNC)
        else $error("unsupported function not refused");

    a_in_write: assert property (@(posedge clk) disable iff (rst)
        s_take and (req.func == FC_WR_REG) and (req.addr <= IN_LAST)
        |-> ##4 rsp_ff.exc == EXC_ADDR)
        else $error("input area write not refused");

    a_in_read_range: assert property (@(posedge clk) disable iff (rst)
        s_take and (req.func == FC_RD_INREG) and (req.addr == 16'h0004)
        |-> ##4 rsp_ff.exc == EXC_ADDR)
        else $error("input read past word 3 accepted");

    a_coil_edge: assert property (@(posedge clk) disable iff (rst)
        s_take and (req.func == FC_RD_COILS) and (req.addr == COIL_LAST)
        |-> ##4 rsp_ff.exc == EXC_NONE)
        else $error("last coil refused");

    a_no_wr_on_exc: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && rsp_ff.exc != EXC_NONE
        |-> $stable(cfg_ff))
        else $error("refused request changed output words");

    a_bad_velocity: assert property (@(posedge clk) disable iff (rst)
        s_take and (req.func == FC_WR_REG) and
        (req.addr == OUT_BASE + 16'h0006) and (req.wdata == 16'h0000)
        |-> ##4 rsp_ff.exc == EXC_VALUE)
        else $error("bad velocity format accepted");

    a_hold_both: assert property (@(posedge clk) disable iff (rst)
        s_take and (req.func == FC_RD_HOLD) and (req.addr <= IN_LAST)
        |-> ##4 rsp_ff.exc == EXC_NONE && rsp_ff.rdata ==
            $past(in_words[req_ff.addr[1:0]*16 +: 16]))
        else $error("holding read of input word wrong");

endmodule

// ==== mer_pkg.sv ====
package mer_pkg;

    // ------------------------------------------------------------
    // Area sizes and base addresses
    // ------------------------------------------------------------
    localparam int unsigned IN_WORDS = 4;           // Input words
    localparam int unsigned OUT_WORDS = 9;          // Output words
    localparam logic [15:0] IN_BASE = 16'h0000;     // First input word
    localparam logic [15:0] OUT_BASE = 16'h0400;    // Word 1024
    localparam logic [15:0] OUT_LAST = 16'h0408;    // Word 1032
    localparam logic [15:0] COIL_BASE = 16'h4000;   // Bit 16,384
    localparam logic [15:0] COIL_LAST = 16'h408F;   // Bit 16,527
    localparam logic [15:0] DIN_LAST = 16'h003F;    // Bit 63
    localparam logic [15:0] IN_LAST = 16'h0003;     // Word 3

    // ------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_RD_COILS = 8'h01;     // Read coils
    localparam logic [7:0] FC_RD_DIN = 8'h02;       // Read discrete inputs
    localparam logic [7:0] FC_RD_HOLD = 8'h03;      // Read holding words
    localparam logic [7:0] FC_RD_INREG = 8'h04;     // Read input words
    localparam logic [7:0] FC_WR_COIL = 8'h05;      // Write single coil
    localparam logic [7:0] FC_WR_REG = 8'h06;       // Write single word
    localparam logic [7:0] FC_WR_COILS = 8'h0F;     // Write multiple coils
    localparam logic [7:0] FC_WR_REGS = 8'h10;      // Write multiple words
    localparam logic [7:0] FC_MASK_WR = 8'h16;      // Mask write
    localparam logic [7:0] FC_RD_WR = 8'h17;        // Read/write words

    // ------------------------------------------------------------
    // Exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] EXC_NONE = 8'h00;        // Success
    localparam logic [7:0] EXC_FUNC = 8'h01;        // Illegal function
    localparam logic [7:0] EXC_ADDR = 8'h02;        // Illegal data address
    localparam logic [7:0] EXC_VALUE = 8'h03;       // Illegal data value

    // ------------------------------------------------------------
    // Output word reset values (power-up configuration)
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CMD = 16'h0000;     // Command word
    localparam logic [15:0] RST_PRE_LO = 16'h0000;  // Preset low
    localparam logic [15:0] RST_PRE_HI = 16'h0000;  // Preset high
    localparam logic [15:0] RST_CFG = 16'h0000;     // Configuration word
    localparam logic [15:0] RST_CPT_LO = 16'h0000;  // Counts/turn low
    localparam logic [15:0] RST_CPT_HI = 16'h0001;  // Counts/turn high
    localparam logic [15:0] RST_VEL = 16'h1F04;     // Velocity format
    localparam logic [15:0] RST_TMR_LO = 16'h0000;  // Range low
    localparam logic [15:0] RST_TMR_HI = 16'h0000;  // Range high

    // ------------------------------------------------------------
    // Output word indices and field limits
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CMD = 4'h0;          // Command word
    localparam logic [3:0] IDX_CPT_LO = 4'h4;       // Counts/turn low
    localparam logic [3:0] IDX_CPT_HI = 4'h5;       // Counts/turn high
    localparam logic [3:0] IDX_VEL = 4'h6;          // Velocity format
    localparam logic [31:0] CPT_MIN = 32'h0000_0002; // Least counts/turn
    localparam logic [31:0] CPT_MAX = 32'h0001_0000; // Most counts/turn
    localparam logic [15:0] CMD_RSVD = 16'hFF00;    // Reserved command bits
    localparam logic [15:0] VEL_PPS = 16'h1F04;     // Pulses per second
    localparam logic [15:0] VEL_PPMS = 16'h1F05;    // Pulses per ms
    localparam logic [15:0] VEL_PPM = 16'h1F07;     // Pulses per minute
    localparam logic [15:0] VEL_RPM = 16'h1F0F;     // Revolutions per minute
    localparam logic [3:0] CMD_ARM = 4'h2;          // Command arm nibble
    localparam logic [3:0] CMD_FIRE = 4'hD;         // Command fire nibble

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] func;   // Function code
        logic [15:0] addr;  // Word or bit address
        logic [15:0] wdata; // Write word, coil state or AND mask
        logic [15:0] omask; // OR mask for mask write
    } mer_req_t;

    typedef struct packed {
        logic [7:0] exc;    // Exception code, zero on success
        logic [15:0] rdata; // Read word or bit in bit 0
    } mer_rsp_t;

    typedef enum {
        ST_IDLE,
        ST_READ,
        ST_CHECK,
        ST_WRITE,
        ST_DONE
    } mer_state_t;

endpackage

// ==== mer_word_mem.sv ====
module mer_word_mem
    import mer_pkg::*;
#(
    parameter int unsigned DEPTH = OUT_WORDS // Number of words
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, loads configuration
    input wire logic [3:0] raddr, // Read index
    output logic [15:0] rdata_ff, // Registered read data
    input wire logic we, // Write strobe
    input wire logic [3:0] waddr, // Write index
    input wire logic [15:0] wdata // Write data
);

    // ------------------------------------------------------------
    // Storage, loaded with the power-up configuration on reset
    // ------------------------------------------------------------
    logic [15:0] mem_ff [DEPTH]; // Output words

    // Reset value of each word
    function automatic logic [15:0] rst_word(input int unsigned i);
        unique case (i)
            0: rst_word = RST_CMD;
            1: rst_word = RST_PRE_LO;
            2: rst_word = RST_PRE_HI;
            3: rst_word = RST_CFG;
            4: rst_word = RST_CPT_LO;
            5: rst_word = RST_CPT_HI;
            6: rst_word = RST_VEL;
            7: rst_word = RST_TMR_LO;
            default: rst_word = RST_TMR_HI;
        endcase
    endfunction

    // Write port
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst) begin
                mem_ff[i] <= rst_word(i);
            end else if (we && waddr == 4'(i)) begin
                mem_ff[i] <= wdata;
            end
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else if (raddr < 4'(DEPTH)) begin
            rdata_ff <= mem_ff[raddr];
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

endmodule

// ==== mer_cli.sv ====
// ------------------------------------------------------------
// Client model: issues one request, collects the answer
// ------------------------------------------------------------
module mer_cli
    import mer_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Reset
    input wire logic go, // Start one request
    input wire mer_req_t cmd, // Request to send
    output logic req_valid, // Request present
    input wire logic req_ready, // Request taken
    output mer_req_t req, // Request fields
    input wire logic rsp_valid, // Answer present
    input wire mer_rsp_t rsp_ff, // Answer fields
    output logic done, // Answer caught, one cycle
    output mer_rsp_t got // Caught answer
);
    timeunit 1ns;
    timeprecision 1ps;
    // Hold request until taken; released lines show the inverse
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            req_valid <= 1'b0;
            req <= '0;
        end else if (go && !req_valid) begin
            req_valid <= 1'b1;
            req <= cmd;
        end else if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            req <= ~req;
        end
        // One-cycle answer is caught in its own cycle
        if (rsp_valid) begin
            done <= 1'b1;
            got <= rsp_ff;
        end
    end
endmodule

// ==== mer_tb.sv ====
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mer_pkg::*;
    // ------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------
    logic clk, rst, go, req_valid, req_ready, rsp_valid, done;
    logic preset, store;
    mer_req_t cmd, req;
    mer_rsp_t rsp, got;
    logic [63:0] in_words;
    logic [143:0] cfg;
    logic [31:0] cpt;
    logic [15:0] m [9]; // Expected output words
    int fails, tests_run, seed, cyc, pre_n, sto_n, pre_x, sto_x;
    logic [7:0] fl [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h0F, 8'h10, 8'h16, 8'h17, 8'h00, 8'h07, 8'h08, 8'h11, 8'h18,
        8'hFF};
    logic [15:0] al [13] = '{16'h0000, 16'h0003, 16'h0004, 16'h003F,
        16'h0040, 16'h03FF, 16'h0400, 16'h0408, 16'h0409, 16'h3FFF,
        16'h4000, 16'h408F, 16'h4090};
    mer_core u_mer_core (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .in_words(in_words),
        .rsp_valid(rsp_valid), .rsp_ff(rsp), .cfg_ff(cfg), .cpt_ff(cpt),
        .preset_ff(preset), .store_ff(store));
    mer_cli u_mer_cli (.clk(clk), .rst(rst), .go(go), .cmd(cmd),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_ff(rsp), .done(done), .got(got));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Pulse counters and hang guard
    always @(posedge clk) begin
        cyc++;
        if (preset === 1'b1) pre_n++;
        if (store === 1'b1) sto_n++;
        if (cyc == 30000) begin
            fails++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // Expected answer; updates the word mirror on accepted writes
    // ------------------------------------------------------------
    function automatic mer_rsp_t predict(mer_req_t r);
        logic [15:0] b, nw;
        logic [31:0] c;
        logic ok, wr, bad;
        int i;
        predict = '0;
        b = r.addr - COIL_BASE;
        ok = 1'b0;
        wr = 1'b0;
        i = r.addr[3:0];
        nw = r.wdata;
        case (r.func)
            FC_RD_COILS, FC_WR_COIL, FC_WR_COILS: begin
                if (r.addr >= COIL_BASE && r.addr <= COIL_LAST) begin
                    ok = 1'b1;
                    i = b[7:4];
                    nw = m[i];
                    nw[b[3:0]] = r.wdata[0];
                    wr = r.func != FC_RD_COILS;
                    predict.rdata = {15'h0, m[i][b[3:0]]};
                end
            end
            FC_RD_DIN: begin
                ok = r.addr <= DIN_LAST;
                predict.rdata = {15'h0, in_words[r.addr[5:0]]};
            end
            FC_RD_HOLD, FC_RD_WR, FC_RD_INREG: begin
                ok = r.addr <= IN_LAST;
                predict.rdata = in_words[{r.addr[1:0], 4'h0} +: 16];
                if (!ok && r.func != FC_RD_INREG && r.addr >= OUT_BASE &&
                    r.addr <= OUT_LAST) begin
                    ok = 1'b1;
                    predict.rdata = m[i];
                end
            end
            FC_WR_REG, FC_WR_REGS, FC_MASK_WR: begin
                ok = r.addr >= OUT_BASE && r.addr <= OUT_LAST;
                wr = ok;
                if (ok && r.func == FC_MASK_WR)
                    nw = (m[i] & r.wdata) | (r.omask & ~r.wdata);
            end
            default: predict.exc = EXC_FUNC;
        endcase
        if (!ok && predict.exc == EXC_NONE) predict.exc = EXC_ADDR;
        if (wr) begin
            c = i == 4 ? {m[5], nw} : i == 5 ? {nw, m[4]} : CPT_MIN;
            bad = (i == 0 && nw[15:8] != 8'h00) || c < CPT_MIN ||
                c > CPT_MAX || (i == 6 && !(nw inside {VEL_PPS,
                VEL_PPMS, VEL_PPM, VEL_RPM}));
            if (bad) begin
                predict.exc = EXC_VALUE;
            end else begin
                if (i == 0 && m[0][3:0] == CMD_ARM && nw[3:0] == CMD_FIRE)
                    pre_x++;
                if (i == 0 && m[0][7:4] == CMD_ARM && nw[7:4] == CMD_FIRE)
                    sto_x++;
                m[i] = nw;
                predict.rdata = nw;
            end
        end
        if (predict.exc != EXC_NONE) predict.rdata = '0;
    endfunction
    // Power-up configuration into the mirror
    task automatic init_m;
        m = '{RST_CMD, RST_PRE_LO, RST_PRE_HI, RST_CFG, RST_CPT_LO,
            RST_CPT_HI, RST_VEL, RST_TMR_LO, RST_TMR_HI};
    endtask
    task automatic cfg_chk;
        for (int k = 0; k < 9; k++)
            `CHK("cfg", m[k], cfg[16*k +: 16])
        `CHK("cpt", {m[5], m[4]}, cpt)
    endtask
    // One request through the client, then answer, output words and counts per turn compared
    task automatic xfer(logic [7:0] f, logic [15:0] a, logic [31:0] w,
        logic [31:0] o);
        mer_rsp_t e;
        int n;
        @(posedge clk);
        in_words <= {$random(seed), $random(seed)};
        cmd <= '{f, a, w[15:0], o[15:0]};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        e = predict('{f, a, w[15:0], o[15:0]});
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 40);
        `CHK("done", 1'b1, done)
        `CHK("cycles", 6, n)
        `CHK("exc", e.exc, got.exc)
        `CHK("rdata", e.rdata, got.rdata)
        cfg_chk();
    endtask
    task automatic wrap_up;
        $display("counts run %0d mismatched %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 93012;
        rst = 1'b1;
        go = 1'b0;
        cmd = '0;
        in_words = '0;
        init_m();
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cfg_chk();
        $display("test reset done");
        foreach (fl[f]) foreach (al[a])
            xfer(fl[f], al[a], $random(seed), $random(seed));
        $display("test codes done");
        // Command transitions, reserved bits, velocity list, halves
        xfer(FC_WR_REG, 16'h0400, 32'h0002, 0);
        xfer(FC_WR_REG, 16'h0400, 32'h000D, 0);
        xfer(FC_WR_REG, 16'h0400, 32'h0020, 0);
        xfer(FC_WR_REG, 16'h0400, 32'h00D0, 0);
        xfer(FC_WR_REG, 16'h0400, 32'h0100, 0);
        for (int v = 16'h1F03; v < 16'h1F10; v++)
            xfer(FC_WR_REG, 16'h0406, v, 0);
        xfer(FC_WR_REG, 16'h0406, 32'h0000, 0);
        xfer(FC_WR_REG, 16'h0404, 32'h0001, 0);
        xfer(FC_WR_REG, 16'h0405, 32'h0000, 0);
        xfer(FC_MASK_WR, 16'h0403, 32'hF0F0, 32'h0A0A);
        xfer(FC_WR_REG, 16'h0002, 32'h1234, 0);
        `CHK("preset", pre_x, pre_n)
        `CHK("store", sto_x, sto_n)
        $display("test words done");
        for (int k = 0; k < 400; k++)
            xfer(fl[$unsigned($random(seed)) % 16],
                al[$unsigned($random(seed)) % 13] + $random(seed) % 3,
                $random(seed), $random(seed));
        $display("test random done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        init_m();
        @(negedge clk);
        cfg_chk();
        $display("test rereset done");
        wrap_up();
    end
endmodule
